// ==== rtl/boot_strap_pkg.sv ====
package boot_strap_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [11:0] switch_control_off  = 12'h000;
	localparam logic [11:0] strap_status_off    = 12'h004;
	localparam logic [11:0] boot_status_off     = 12'h008;

	// ==========================================================
	// Field positions
	localparam int halt_bit          = 0;
	localparam int refclk_bit        = 0;
	localparam int port_clk_lsb      = 1;
	localparam int op_mode_lsb       = 4;
	localparam int state_lsb         = 0;
	localparam int eeprom_bit        = 4;
	localparam int multi_bit         = 5;
	localparam int detach_bit        = 6;
	localparam int reserved_bit      = 7;
	localparam int jump_lsb          = 8;
	localparam int low_latency_bit   = 10;

	// ==========================================================
	// Reset values and codes
	localparam logic [31:0] switch_control_rst = 32'h0000_0000;
	localparam logic [31:0] unmapped_read      = 32'h0000_0000;
	localparam logic        refclk_100mhz      = 1'b0;
	localparam logic        refclk_125mhz      = 1'b1;
	localparam int          refclk_100_khz     = 100000;
	localparam int          refclk_125_khz     = 125000;

	localparam logic [3:0] mode_single         = 4'h0;
	localparam logic [3:0] mode_single_eeprom  = 4'h1;
	localparam logic [3:0] mode_single_jump0   = 4'h2;
	localparam logic [3:0] mode_single_jump1   = 4'h3;
	localparam logic [3:0] mode_reserved_lo    = 4'h4;
	localparam logic [3:0] mode_reserved_hi    = 4'h7;
	localparam logic [3:0] mode_single_ll      = 4'h8;
	localparam logic [3:0] mode_single_ll_ee   = 4'h9;
	localparam logic [3:0] mode_multi_unatt    = 4'ha;
	localparam logic [3:0] mode_multi_unatt_ee = 4'hb;
	localparam logic [3:0] mode_multi_dis      = 4'hc;
	localparam logic [3:0] mode_multi_dis_ee   = 4'hd;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		st_reset  = 2'b00,
		st_capture = 2'b01,
		st_halt   = 2'b11,
		st_run    = 2'b10
	} boot_state_e;

	typedef struct packed {
		logic [3:0] op_mode;
		logic [1:0] port_clk;
		logic       refclk_sel;
	} strap_s;

	typedef struct packed {
		logic       single_part;
		logic       multi_part;
		logic       eeprom_init;
		logic [1:0] jump;
		logic       detach_ports;
		logic       low_latency;
		logic       reserved;
	} mode_decode_s;

endpackage

// ==== rtl/mode_decoder.sv ====
`timescale 1ns/100ps

// ==========================================================
// Switch mode decoder
module mode_decoder (
	input  wire logic [3:0]                 op_mode,
	output      boot_strap_pkg::mode_decode_s dec
);

	always_comb begin
		dec = '0;
		case (op_mode)
			boot_strap_pkg::mode_single: begin
				dec.single_part = 1'b1;
			end
			boot_strap_pkg::mode_single_eeprom: begin
				dec.single_part = 1'b1;
				dec.eeprom_init = 1'b1;
			end
			boot_strap_pkg::mode_single_jump0: begin
				dec.single_part = 1'b1;
				dec.eeprom_init = 1'b1;
				dec.jump        = 2'h1;
			end
			boot_strap_pkg::mode_single_jump1: begin
				dec.single_part = 1'b1;
				dec.eeprom_init = 1'b1;
				dec.jump        = 2'h2;
			end
			boot_strap_pkg::mode_single_ll: begin
				dec.single_part = 1'b1;
				dec.low_latency = 1'b1;
			end
			boot_strap_pkg::mode_single_ll_ee: begin
				dec.single_part = 1'b1;
				dec.low_latency = 1'b1;
				dec.eeprom_init = 1'b1;
			end
			boot_strap_pkg::mode_multi_unatt: begin
				dec.multi_part = 1'b1;
			end
			boot_strap_pkg::mode_multi_unatt_ee: begin
				dec.multi_part  = 1'b1;
				dec.eeprom_init = 1'b1;
			end
			boot_strap_pkg::mode_multi_dis: begin
				dec.multi_part   = 1'b1;
				dec.detach_ports = 1'b1;
			end
			boot_strap_pkg::mode_multi_dis_ee: begin
				dec.multi_part   = 1'b1;
				dec.detach_ports = 1'b1;
				dec.eeprom_init  = 1'b1;
			end
			default: begin
				// Reserved codes enable no mode; status shows them so software can catch a bad strap.
				dec.reserved = 1'b1;
			end
		endcase
	end

endmodule

// ==== rtl/reset_halt_strap.sv ====
`timescale 1ns/100ps

// Notes on behaviour
// - Frequency select low means 100 MHz reference, high means 125 MHz.
// - Two-bit clock mode strap selects the port clocking mode.
// - While fundamental reset is asserted, all internal logic is held in reset.
// - Hold request seen during reset leaves device halted with SMBus kept alive.
// - While halted, register reads and writes are accepted.
// - Clearing the halt bit ends the halt and starts normal operation.
// - Code 0x0 single partition; 0x1 single partition after EEPROM load.
// - Code 0x2 uses EEPROM jump-0, code 0x3 uses jump-1.
// - Multi-partition modes with unattached or disabled ports, with or without EEPROM.
module reset_halt_strap (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        fundamental_reset_n,
	input  wire logic        reset_hold_request,
	input  wire logic [1:0]  port_clocking_strap,
	input  wire logic        refclk_freq_select,
	input  wire logic [3:0]  operating_mode_strap,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	output      logic        logic_reset,
	output      logic        smbus_enable,
	output      logic        switch_run,
	output      logic [1:0]  port_clock_mode,
	output      logic        refclk_is_125,
	output      logic [17:0] refclk_khz,
	output      logic [3:0]  switch_mode,
	output      boot_strap_pkg::mode_decode_s mode_flags
);

	// ==========================================================
	// Pin synchronisers
	// Straps are static, so a two-stage sync per bit is enough; no bus-skew hazard once stable.
	localparam int sync_w = 9;

	logic [sync_w-1:0] pin_meta_r;
	logic [sync_w-1:0] pin_sync_r;
	logic [sync_w-1:0] pin_raw;

	assign pin_raw = {fundamental_reset_n, reset_hold_request, port_clocking_strap,
		refclk_freq_select, operating_mode_strap};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
		end
	end

	logic                   perst_n_s;
	logic                   hold_req_s;
	boot_strap_pkg::strap_s strap_s_now;

	assign perst_n_s           = pin_sync_r[8];
	assign hold_req_s          = pin_sync_r[7];
	assign strap_s_now = '{op_mode: pin_sync_r[3:0], port_clk: pin_sync_r[6:5], refclk_sel: pin_sync_r[4]};

	// ==========================================================
	// Boot sequencer
	boot_strap_pkg::boot_state_e state_r;
	boot_strap_pkg::boot_state_e state_nxt;
	logic                        halt_r;
	logic                        hold_seen_r;
	boot_strap_pkg::strap_s      strap_r;
	logic                        halt_clear;
	boot_strap_pkg::mode_decode_s mode_dec;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			boot_strap_pkg::st_reset: begin
				if (perst_n_s) begin
					state_nxt = boot_strap_pkg::st_capture;
				end
			end
			boot_strap_pkg::st_capture: begin
				if (hold_seen_r) begin
					state_nxt = boot_strap_pkg::st_halt;
				end else begin
					state_nxt = boot_strap_pkg::st_run;
				end
			end
			boot_strap_pkg::st_halt: begin
				if (!halt_r) begin
					state_nxt = boot_strap_pkg::st_run;
				end
			end
			default: begin
				state_nxt = boot_strap_pkg::st_run;
			end
		endcase
		if (!perst_n_s) begin
			state_nxt = boot_strap_pkg::st_reset;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= boot_strap_pkg::st_reset;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Hold request is latched any time during the reset sequence, not only at its release edge.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hold_seen_r <= 1'b0;
		end else if (state_r == boot_strap_pkg::st_reset) begin
			if (!perst_n_s && hold_req_s) begin
				hold_seen_r <= 1'b1;
			end else if (!perst_n_s) begin
				hold_seen_r <= hold_seen_r;
			end else begin
				hold_seen_r <= hold_seen_r | hold_req_s;
			end
		end else if (state_r == boot_strap_pkg::st_run) begin
			hold_seen_r <= 1'b0;
		end
	end

	// Straps sampled once at release; later pin changes are ignored.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strap_r <= '0;
		end else if (state_r == boot_strap_pkg::st_reset && perst_n_s) begin
			strap_r <= strap_s_now;
		end
	end

	// ==========================================================
	// APB slave
	// One wait state: pready rises one cycle after penable. The bus is served in halt and run
	// but not during fundamental reset, when a request is answered with an error.
	logic apb_access;
	logic apb_live;
	logic [31:0] rd_word;

	assign apb_access = psel && penable && !pready;
	assign apb_live   = state_r != boot_strap_pkg::st_reset;
	assign halt_clear = apb_access && apb_live && pwrite && paddr == boot_strap_pkg::switch_control_off
		&& !pwdata[boot_strap_pkg::halt_bit];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			halt_r <= 1'b0;
		end else if (state_r == boot_strap_pkg::st_reset) begin
			halt_r <= 1'b1;
		end else if (state_r == boot_strap_pkg::st_capture) begin
			halt_r <= hold_seen_r;
		end else if (halt_clear) begin
			halt_r <= 1'b0;
		end
	end

	always_comb begin
		if (paddr == boot_strap_pkg::switch_control_off) begin
			rd_word = 32'h0000_0000;
			rd_word[boot_strap_pkg::halt_bit] = halt_r;
		end else if (paddr == boot_strap_pkg::strap_status_off) begin
			rd_word = 32'h0000_0000;
			rd_word[boot_strap_pkg::refclk_bit] = strap_r.refclk_sel;
			rd_word[boot_strap_pkg::port_clk_lsb +: 2] = strap_r.port_clk;
			rd_word[boot_strap_pkg::op_mode_lsb +: 4] = strap_r.op_mode;
		end else if (paddr == boot_strap_pkg::boot_status_off) begin
			rd_word = 32'h0000_0000;
			rd_word[boot_strap_pkg::state_lsb +: 2] = state_r;
			rd_word[boot_strap_pkg::eeprom_bit] = mode_dec.eeprom_init;
			rd_word[boot_strap_pkg::multi_bit] = mode_dec.multi_part;
			rd_word[boot_strap_pkg::detach_bit] = mode_dec.detach_ports;
			rd_word[boot_strap_pkg::reserved_bit] = mode_dec.reserved;
			rd_word[boot_strap_pkg::jump_lsb +: 2] = mode_dec.jump;
			rd_word[boot_strap_pkg::low_latency_bit] = mode_dec.low_latency;
		end else begin
			rd_word = boot_strap_pkg::unmapped_read;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= boot_strap_pkg::switch_control_rst;
		end else begin
			pready  <= apb_access;
			pslverr <= apb_access && (!apb_live || paddr[1:0] != 2'b00
				|| (paddr != boot_strap_pkg::switch_control_off && paddr != boot_strap_pkg::strap_status_off
				&& paddr != boot_strap_pkg::boot_status_off));
			prdata  <= (apb_access && !pwrite && apb_live) ? rd_word : 32'h0000_0000;
		end
	end

	// ==========================================================
	// Mode decode and outputs
	mode_decoder u_mode_decoder (
		.op_mode (strap_r.op_mode),
		.dec     (mode_dec)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			logic_reset     <= 1'b1;
			smbus_enable    <= 1'b0;
			switch_run      <= 1'b0;
			port_clock_mode <= 2'b00;
			refclk_is_125   <= 1'b0;
			refclk_khz      <= 18'(boot_strap_pkg::refclk_100_khz);
			switch_mode     <= 4'h0;
			mode_flags      <= '0;
		end else begin
			logic_reset     <= state_nxt != boot_strap_pkg::st_run;
			smbus_enable    <= state_nxt != boot_strap_pkg::st_reset;
			switch_run      <= state_nxt == boot_strap_pkg::st_run;
			port_clock_mode <= strap_r.port_clk;
			refclk_is_125   <= strap_r.refclk_sel == boot_strap_pkg::refclk_125mhz;
			refclk_khz      <= (strap_r.refclk_sel == boot_strap_pkg::refclk_100mhz)
				? 18'(boot_strap_pkg::refclk_100_khz) : 18'(boot_strap_pkg::refclk_125_khz);
			switch_mode     <= strap_r.op_mode;
			mode_flags      <= mode_dec;
		end
	end

endmodule

// ==== tb/board_model.sv ====
`timescale 1ns/100ps

// ========
// Board straps and reset source
module board_model (
	input wire logic                   clk,
	input wire logic                   assert_rst,
	input wire logic                   hold,
	input wire boot_strap_pkg::strap_s want,
	output logic                       fundamental_reset_n = 1'b0,
	output logic                       reset_hold_request = 1'b0,
	output logic [1:0]                 port_clocking_strap = 2'h0,
	output logic                       refclk_freq_select = 1'b0,
	output logic [3:0]                 operating_mode_strap = 4'h0
);
	always @(posedge clk) begin
		fundamental_reset_n <= !assert_rst;
		// Straps only move while the device is in reset.
		if (assert_rst) begin
			reset_hold_request <= hold;
			port_clocking_strap <= want.port_clk;
			refclk_freq_select <= want.refclk_sel;
			// A real board is never strapped to reserved codes 0x4-0x7; they become code 0x0.
			operating_mode_strap <= (want.op_mode[3:2] == 2'b01) ? 4'h0 : want.op_mode;
		end
	end
endmodule

// ==== tb/reset_halt_strap_asserts.sv ====
`timescale 1ns/100ps

// ========
// Sequencing checks
module reset_halt_strap_asserts (
	input wire logic                         clk,
	input wire logic                         reset,
	input wire logic                         fundamental_reset_n,
	input wire logic                         reset_hold_request,
	input wire logic [1:0]                   port_clocking_strap,
	input wire logic                         refclk_freq_select,
	input wire logic [3:0]                   operating_mode_strap,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [11:0]                  paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire logic                         logic_reset,
	input wire logic                         smbus_enable,
	input wire logic                         switch_run,
	input wire logic [1:0]                   port_clock_mode,
	input wire logic                         refclk_is_125,
	input wire logic [17:0]                  refclk_khz,
	input wire logic [3:0]                   switch_mode,
	input wire boot_strap_pkg::mode_decode_s mode_flags
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_refclk;
		refclk_khz == (refclk_is_125 ? 18'h1_E848 : 18'h1_86A0);
	endproperty
	a_refclk: assert property (p_refclk) else $error("refclk khz wrong");

	// The board keeps its straps still while running, so the captured copy must equal the pins.
	property p_straps;
		switch_run |-> port_clock_mode == port_clocking_strap && refclk_is_125 == refclk_freq_select
			&& switch_mode == operating_mode_strap;
	endproperty
	a_straps: assert property (p_straps) else $error("captured straps wrong");

	property p_reset;
		!fundamental_reset_n [*5] |-> logic_reset && !smbus_enable && !switch_run;
	endproperty
	a_reset: assert property (p_reset) else $error("not held in reset");

	property p_halt;
		$rose(smbus_enable) && reset_hold_request |-> !switch_run [*6];
	endproperty
	a_halt: assert property (p_halt) else $error("ran despite hold");

	property p_apb;
		psel && penable && !pready |=> pready;
	endproperty
	a_apb: assert property (p_apb) else $error("no ready");

	property p_err;
		pslverr |-> pready ##1 !pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");

	property p_clear;
		psel && penable && pready && pwrite && paddr == 12'h000 && !pwdata[0] && !pslverr
			&& logic_reset && smbus_enable |-> ##[1:3] switch_run;
	endproperty
	a_clear: assert property (p_clear) else $error("halt not left");

	property p_single;
		switch_run && switch_mode <= 4'h1 |-> mode_flags.single_part && !mode_flags.multi_part
			&& mode_flags.eeprom_init == switch_mode[0];
	endproperty
	a_single: assert property (p_single) else $error("single flags wrong");

	property p_jump;
		switch_run && switch_mode[3:1] == 3'b001 |-> mode_flags.single_part
			&& mode_flags.jump == {switch_mode[0], !switch_mode[0]};
	endproperty
	a_jump: assert property (p_jump) else $error("jump flags wrong");

	property p_multi;
		switch_run && switch_mode >= 4'ha && switch_mode <= 4'hd |-> mode_flags.multi_part
			&& !mode_flags.single_part && mode_flags.eeprom_init == switch_mode[0];
	endproperty
	a_multi: assert property (p_multi) else $error("multi flags wrong");
endmodule

// ==== tb/test_reset_halt_strap.sv ====
`timescale 1ns/100ps

// ========
// Bench
module test_reset_halt_strap;
	logic                         clk = 1'b0;
	logic                         reset = 1'b1;
	logic                         psel = 1'b0;
	logic                         penable = 1'b0;
	logic                         pwrite = 1'b0;
	logic [11:0]                  paddr = 12'h000;
	logic [31:0]                  pwdata = 32'h0000_0000;
	logic [31:0]                  prdata, rd;
	logic                         pready, pslverr, err, logic_reset, smbus_enable, switch_run;
	logic                         frn, hold_pin, rfs, refclk_is_125;
	logic                         assert_rst = 1'b1;
	logic                         hold = 1'b0;
	logic [1:0]                   pcs, port_clock_mode;
	logic [3:0]                   oms, switch_mode;
	logic [17:0]                  refclk_khz;
	logic [2:0]                   st;
	boot_strap_pkg::strap_s       want = 7'h00;
	boot_strap_pkg::mode_decode_s mode_flags;
	int                           fails = 0;
	int                           comparisons = 0;
	logic [3:0]                   modes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};

	always #5 clk = ~clk;
	assign st = {switch_run, smbus_enable, logic_reset};

	board_model board (.clk(clk), .assert_rst(assert_rst), .hold(hold), .want(want), .fundamental_reset_n(frn),
		.reset_hold_request(hold_pin), .port_clocking_strap(pcs), .refclk_freq_select(rfs),
		.operating_mode_strap(oms));

	reset_halt_strap dut (.clk(clk), .reset(reset), .fundamental_reset_n(frn), .reset_hold_request(hold_pin),
		.port_clocking_strap(pcs), .refclk_freq_select(rfs), .operating_mode_strap(oms), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .logic_reset(logic_reset), .smbus_enable(smbus_enable), .switch_run(switch_run),
		.port_clock_mode(port_clock_mode), .refclk_is_125(refclk_is_125), .refclk_khz(refclk_khz),
		.switch_mode(switch_mode), .mode_flags(mode_flags));

	task close_out;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// State code is {switch_run, smbus_enable, logic_reset}.
	task await(input logic [2:0] v);
		int n;
		n = 0;
		while (st !== v && n < 50) begin
			@(posedge clk);
			n++;
		end
		check("state", {29'h0, v}, {29'h0, st});
		if (st !== v) close_out;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("pready", 32'h0000_0001, {31'h0, pready});
		if (pready !== 1'b1) close_out;
	endtask

	task boot(input logic [3:0] m, input logic f, input logic [1:0] p, input logic h);
		@(posedge clk);
		assert_rst <= 1'b1;
		hold <= h;
		await(3'b001);
		apb(1'b0, 12'h004, 32'h0000_0000);
		check("refused", 32'h0000_0001, {31'h0, err});
		want <= '{op_mode: m, port_clk: p, refclk_sel: f};
		@(posedge clk);
		@(posedge clk);
		assert_rst <= 1'b0;
		await(h ? 3'b011 : 3'b110);
	endtask

	function automatic logic [31:0] exp_boot(input logic [3:0] m);
		logic [1:0] j;
		j = (m == 4'h2) ? 2'b01 : ((m == 4'h3) ? 2'b10 : 2'b00);
		return {22'h0, j, 2'b00, (m >= 4'ha), 3'b000, 2'b10};
	endfunction

	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			boot(modes[i], i[0], i[2:1], 1'b0);
			check("mode", {28'h0, modes[i]}, {28'h0, switch_mode});
			check("port clock", {30'h0, i[2:1]}, {30'h0, port_clock_mode});
			check("khz", i[0] ? 32'h0001_E848 : 32'h0001_86A0, {14'h0, refclk_khz});
			apb(1'b0, 12'h004, 32'h0000_0000);
			check("straps", {24'h0, modes[i], 1'b0, i[2:1], i[0]}, rd);
			apb(1'b0, 12'h008, 32'h0000_0000);
			check("boot", exp_boot(modes[i]), rd & 32'h0000_0323);
		end
		boot(4'hb, 1'b1, 2'b10, 1'b1);
		apb(1'b0, 12'h004, 32'h0000_0000);
		check("halt straps", 32'h0000_00B5, rd);
		apb(1'b0, 12'h000, 32'h0000_0000);
		check("halt bit", 32'h0000_0001, rd);
		apb(1'b1, 12'h000, 32'h0000_0001);
		apb(1'b0, 12'h008, 32'h0000_0000);
		check("still halted", 32'h0000_0003, rd & 32'h0000_0003);
		apb(1'b1, 12'h000, 32'h0000_0000);
		await(3'b110);
		apb(1'b0, 12'h00c, 32'h0000_0000);
		check("unmapped err", 32'h0000_0001, {31'h0, err});
		check("unmapped data", 32'h0000_0000, rd);
		close_out;
	end
endmodule

bind reset_halt_strap reset_halt_strap_asserts chk (.clk(clk), .reset(reset), .fundamental_reset_n(fundamental_reset_n),
	.reset_hold_request(reset_hold_request), .port_clocking_strap(port_clocking_strap),
	.refclk_freq_select(refclk_freq_select), .operating_mode_strap(operating_mode_strap), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.logic_reset(logic_reset), .smbus_enable(smbus_enable), .switch_run(switch_run),
	.port_clock_mode(port_clock_mode), .refclk_is_125(refclk_is_125), .refclk_khz(refclk_khz),
	.switch_mode(switch_mode), .mode_flags(mode_flags));
